//--- shared/angle_hex_consts.vh
// Constants for the angle and ASCII/hex conversion datapath.
// Assumes an APB register bus with 32-bit data.
`ifndef ANGLE_HEX_CONSTS_VH
`define ANGLE_HEX_CONSTS_VH
// Register byte addresses
`define REG_ACC 12'h000
`define REG_STACK1 12'h004
`define REG_CMD 12'h008
`define REG_STATUS 12'h00c
`define REG_MEM_ADDR 12'h010
`define REG_MEM_DATA 12'h014
`define REG_FIFO 12'h018
// Command codes (low bits of command register)
`define OP_DEG_TO_RAD 3'h1
`define OP_RAD_TO_DEG 3'h2
`define OP_ASCII_TO_HEX 3'h3
`define OP_HEX_TO_ASCII 3'h4
`define OP_LOAD_ADDRESS 3'h5
`define OP_LOAD_REAL 3'h6
// Command register fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DST_LSB 8
`define CMD_DST_MSB 15
// Status bit positions
`define ST_ZERO 0
`define ST_NEG 1
`define ST_BADPTR 2
`define ST_VALID 3
`define ST_UNDER 4
`define ST_NONDEC 5
`define ST_BUSY 8
// pi/180 and 180/pi as single precision
`define DEG_TO_RAD_K 32'h3c8efa35
`define RAD_TO_DEG_K 32'h42652ee1
// Word memory size
`define MEM_WORDS 256
`define MEM_AW 8
`endif

//--- rtl/conv_fifo.v
// Empty unit: the result FIFO module lives in the converter's own file.
// Assumes the converter file is read in every flow.

//--- rtl/angle_and_ascii_hex_converter.v
// Angle conversion and ASCII/hex table conversion datapath, APB slave.
// Assumes synchronous APB master on sys_clk; table length fits memory.
`timescale 1ns/1ps
`default_nettype none
`include "angle_hex_consts.vh"
module angle_and_ascii_hex_converter (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Rung enable
  input wire rung_enable,
  // Discrete flags
  output wire zero_result_flag,
  output wire negative_flag,
  output wire bad_pointer_flag,
  output wire valid_float_flag,
  output wire underflow_flag,
  output wire non_decimal_flag,
  output wire busy
);
  localparam S_IDLE = 3'h0;
  localparam S_MUL = 3'h1;
  localparam S_RD = 3'h2;
  localparam S_WR = 3'h3;
  localparam S_DONE = 3'h4;

  reg [31:0] acc_q;
  reg [31:0] stack1_q;
  reg [5:0] flags_q;
  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [15:0] src_q;
  reg [15:0] dst_q;
  reg [15:0] left_q;
  reg half_q;
  reg [3:0] digit_q;
  reg [7:0] mem_ptr_q;
  reg [15:0] mem_q [0:`MEM_WORDS-1];
  reg [31:0] rd_mux;
  reg [31:0] prdata_q;

  // Float multiply, truncating, with underflow flush to zero
  function [32:0] fmul;
    input [31:0] a;
    input [31:0] b;
    reg [47:0] p;
    reg [9:0] e;
    reg [22:0] m;
    begin
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'd127;
      if (p[47]) begin
        m = p[46:24];
        e = e + 10'd1;
      end else begin
        m = p[45:23];
      end
      if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
        fmul = {1'b0, a[31] ^ b[31], 31'h0};
      else if (e[9] || e == 10'd0)
        fmul = {1'b1, a[31] ^ b[31], 31'h0};
      else if (e >= 10'd255)
        fmul = {1'b0, a[31] ^ b[31], 8'hff, 23'h0};
      else
        fmul = {1'b0, a[31] ^ b[31], e[7:0], m};
    end
  endfunction

  // ASCII code to digit; bit 4 marks an invalid code
  function [4:0] to_digit;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        to_digit = {1'b0, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46)
        to_digit = {1'b0, c[3:0] + 4'h9};
      else
        to_digit = 5'h10;
    end
  endfunction

  // Digit to ASCII code
  function [7:0] to_ascii;
    input [3:0] d;
    begin
      to_ascii = (d <= 4'h9) ? {4'h3, d} : {4'h4, d - 4'h9};
    end
  endfunction

  // Octal word address to binary
  function [15:0] oct_to_bin;
    input [15:0] o;
    begin
      oct_to_bin = {4'h0, o[14:12], o[10:8], o[6:4], o[2:0]};
    end
  endfunction

  // Magnitude zero, either sign
  function is_zero;
    input [31:0] x;
    begin
      is_zero = (x[30:0] == 31'h0);
    end
  endfunction

  // Exponent not all ones
  function float_ok;
    input [31:0] x;
    begin
      float_ok = (x[30:23] != 8'hff);
    end
  endfunction

  wire [32:0] prod = fmul(acc_q, (op_q == `OP_DEG_TO_RAD) ? `DEG_TO_RAD_K : `RAD_TO_DEG_K);
  wire wr_en = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire src_bad = (src_q >= `MEM_WORDS);
  wire dst_bad = (dst_q >= `MEM_WORDS);
  wire start = wr_en && (paddr == `REG_CMD) && (state_q == S_IDLE) && rung_enable;

  // Result words queue ahead of the memory write port
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [15:0] fifo_in_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [15:0] fifo_out_data;
  reg [15:0] fifo_dst_q;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_q;
  assign busy = (state_q != S_IDLE);
  assign zero_result_flag = flags_q[`ST_ZERO];
  assign negative_flag = flags_q[`ST_NEG];
  assign bad_pointer_flag = flags_q[`ST_BADPTR];
  assign valid_float_flag = flags_q[`ST_VALID];
  assign underflow_flag = flags_q[`ST_UNDER];
  assign non_decimal_flag = flags_q[`ST_NONDEC];

  // Pair of ASCII words packs one byte of two digits
  // Byte expands into two ASCII words, high digit first
  wire [15:0] src_word = src_bad ? 16'h0000 : mem_q[src_q[`MEM_AW-1:0]];
  wire [4:0] dec = to_digit(src_word[7:0]);
  assign fifo_in_valid = (state_q == S_RD) && !src_bad &&
    (op_q == `OP_HEX_TO_ASCII || half_q);
  assign fifo_in_data = (op_q == `OP_HEX_TO_ASCII) ?
    {8'h00, to_ascii(half_q ? src_word[3:0] : src_word[7:4])} :
    {8'h00, digit_q, dec[4] ? 4'h0 : dec[3:0]};
  assign fifo_out_ready = !dst_bad || 1'b1;

  conv_fifo #(.WIDTH(16), .DEPTH(8), .AW(3)) result_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Memory write and software access
  always @(posedge sys_clk) begin
    if (fifo_out_valid && fifo_dst_q < `MEM_WORDS)
      mem_q[fifo_dst_q[`MEM_AW-1:0]] <= fifo_out_data;
    else if (wr_en && paddr == `REG_MEM_DATA && state_q == S_IDLE)
      mem_q[mem_ptr_q] <= pwdata[15:0];
  end

  // APB read mux
  always @* begin
    case (paddr)
      `REG_ACC: rd_mux = acc_q;
      `REG_STACK1: rd_mux = stack1_q;
      `REG_CMD: rd_mux = {16'h0, dst_q[7:0], 5'h0, op_q};
      `REG_STATUS: rd_mux = {23'h0, busy, 2'b00, flags_q};
      `REG_MEM_ADDR: rd_mux = {24'h0, mem_ptr_q};
      `REG_MEM_DATA: rd_mux = {16'h0, mem_q[mem_ptr_q]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Captured in setup, stands through access, zero otherwise
  always @(posedge sys_clk) begin
    if (sys_rst)
      prdata_q <= 32'h0000_0000;
    else if (rd_setup)
      prdata_q <= rd_mux;
    else
      prdata_q <= 32'h0000_0000;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      acc_q <= 32'h0000_0000;
      stack1_q <= 32'h0000_0000;
      flags_q <= 6'h00;
      state_q <= S_IDLE;
      op_q <= 3'h0;
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      left_q <= 16'h0000;
      half_q <= 1'b0;
      digit_q <= 4'h0;
      mem_ptr_q <= 8'h00;
      fifo_dst_q <= 16'h0000;
    end else begin
      if (fifo_out_valid)
        fifo_dst_q <= fifo_dst_q + 16'd1;
      if (wr_en && paddr == `REG_MEM_ADDR)
        mem_ptr_q <= pwdata[7:0];
      if (wr_en && paddr == `REG_STACK1 && !busy)
        stack1_q <= pwdata;
      if (wr_en && paddr == `REG_ACC && !busy) begin
        stack1_q <= acc_q;
        acc_q <= pwdata;
      end
      case (state_q)
        S_IDLE: begin
          if (start) begin
            op_q <= pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
            dst_q <= {8'h00, pwdata[`CMD_DST_MSB:`CMD_DST_LSB]};
            fifo_dst_q <= {8'h00, pwdata[`CMD_DST_MSB:`CMD_DST_LSB]};
            case (pwdata[`CMD_OP_MSB:`CMD_OP_LSB])
              `OP_DEG_TO_RAD, `OP_RAD_TO_DEG:
                state_q <= S_MUL;
              // Length from stack, source from acc
              `OP_ASCII_TO_HEX, `OP_HEX_TO_ASCII: begin
                src_q <= acc_q[15:0];
                left_q <= stack1_q[15:0];
                half_q <= 1'b0;
                digit_q <= 4'h0;
                flags_q[`ST_BADPTR] <= 1'b0;
                flags_q[`ST_NONDEC] <= 1'b0;
                state_q <= (stack1_q[15:0] == 16'h0) ? S_DONE : S_RD;
              end
              `OP_LOAD_ADDRESS: begin
                stack1_q <= acc_q;
                acc_q <= {16'h0, oct_to_bin(pwdata[31:16])};
              end
              `OP_LOAD_REAL: begin
                stack1_q <= acc_q;
                acc_q <= stack1_q;
                flags_q[`ST_VALID] <= float_ok(stack1_q);
              end
              default: state_q <= S_IDLE;
            endcase
          end
        end
        S_MUL: begin
          acc_q <= prod[31:0];
          flags_q[`ST_ZERO] <= is_zero(prod[31:0]);
          flags_q[`ST_NEG] <= prod[31] && !is_zero(prod[31:0]);
          flags_q[`ST_VALID] <= float_ok(prod[31:0]);
          flags_q[`ST_UNDER] <= prod[32];
          state_q <= S_IDLE;
        end
        S_RD: begin
          if (src_bad || dst_bad) begin
            flags_q[`ST_BADPTR] <= 1'b1;
            state_q <= S_DONE;
          end else if (fifo_in_valid && !fifo_in_ready) begin
            state_q <= S_RD;
          end else begin
            if (op_q == `OP_ASCII_TO_HEX && dec[4])
              flags_q[`ST_NONDEC] <= 1'b1;
            if (op_q == `OP_ASCII_TO_HEX && !half_q)
              digit_q <= dec[4] ? 4'h0 : dec[3:0];
            half_q <= !half_q;
            if (op_q == `OP_ASCII_TO_HEX || half_q) begin
              src_q <= src_q + 16'd1;
              left_q <= left_q - 16'd1;
              if (left_q == 16'd1)
                state_q <= S_WR;
            end
            if (op_q == `OP_ASCII_TO_HEX && half_q)
              digit_q <= 4'h0;
          end
        end
        S_WR: begin
          if (!fifo_out_valid)
            state_q <= S_DONE;
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// Result FIFO: flip-flop storage, valid/ready on both sides
module conv_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- sim/conv_checker_assertions.sv
// Checker for the converter's APB, rung and flag ports.
// Assumes it is bound to the converter top; sees ports only.
`timescale 1ns/1ps
`default_nettype none
`include "angle_hex_consts.vh"
module conv_checker (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Rung and flags
  input wire rung_enable,
  input wire zero_result_flag,
  input wire negative_flag,
  input wire bad_pointer_flag,
  input wire valid_float_flag,
  input wire underflow_flag,
  input wire non_decimal_flag,
  input wire busy
);
  wire any_wr = psel && penable && pwrite;
  wire cmd_wr = any_wr && paddr == `REG_CMD;
  wire tbl = pwdata[2:0] == `OP_ASCII_TO_HEX || pwdata[2:0] == `OP_HEX_TO_ASCII;
  wire [5:0] fl = {non_decimal_flag, underflow_flag, valid_float_flag,
    bad_pointer_flag, negative_flag, zero_result_flag};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  status_mirror_a: assert property (psel && penable && !pwrite && paddr == `REG_STATUS
    |-> prdata[5:0] == $past(fl) && prdata[8] == $past(busy)) else $error("status read differs from flags");
  busy_start_a: assert property (cmd_wr && tbl && rung_enable && !busy |=> busy)
    else $error("table command did not start");
  refuse_off_a: assert property (cmd_wr && !rung_enable && !busy |=> !busy)
    else $error("command ran with rung off");
  busy_ends_a: assert property ($rose(busy) |-> ##[1:1000] !busy)
    else $error("table run never finished");
  flags_hold_a: assert property (!any_wr && !$past(any_wr) && !busy && !$past(busy)
    |=> $stable(fl)) else $error("flags changed with no command");
  badptr_cause_a: assert property ($rose(bad_pointer_flag)
    |-> $past(busy) || $past(cmd_wr) || $past(cmd_wr, 2)) else $error("pointer flag without command");
  nondec_cause_a: assert property ($rose(non_decimal_flag)
    |-> $past(busy) || $past(cmd_wr) || $past(cmd_wr, 2)) else $error("digit flag without command");
  under_cause_a: assert property ($rose(underflow_flag)
    |-> $past(cmd_wr) || $past(cmd_wr, 2)) else $error("underflow flag without command");
endmodule
bind angle_and_ascii_hex_converter conv_checker conv_checker_i (.sys_clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rung_enable,
  .zero_result_flag, .negative_flag, .bad_pointer_flag, .valid_float_flag,
  .underflow_flag, .non_decimal_flag, .busy);
`default_nettype wire

//--- sim/angle_and_ascii_hex_converter_tb.sv
// Testbench for the angle and ASCII/hex converter over APB.
// Assumes the checker is bound to the converter elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "angle_hex_consts.vh"
module angle_and_ascii_hex_converter_tb;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, rung_enable = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, zf, nf, bf, vf, uf, df, busy;
  int bad_count = 0, n_tests = 0, i;
  angle_and_ascii_hex_converter angle_and_ascii_hex_converter_i (.sys_clk, .sys_rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rung_enable,
    .zero_result_flag(zf), .negative_flag(nf), .bad_pointer_flag(bf), .valid_float_flag(vf),
    .underflow_flag(uf), .non_decimal_flag(df), .busy);
  initial forever #10 sys_clk = ~sys_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task mem_w(input logic [31:0] a, input logic [31:0] d);
    apb(1, `REG_MEM_ADDR, a);
    apb(1, `REG_MEM_DATA, d);
  endtask
  task mem_chk(input logic [31:0] a, input logic [31:0] e);
    apb(1, `REG_MEM_ADDR, a);
    apb(0, `REG_MEM_DATA, 0);
    chk(r, e);
  endtask
  // Length lands in stack one, source in accumulator
  task params(input logic [31:0] len, input logic [31:0] src);
    apb(1, `REG_ACC, len);
    apb(1, `REG_ACC, src);
  endtask
  task run(input logic [2:0] op, input logic [7:0] dst);
    apb(1, `REG_CMD, {16'h0, dst, 5'h0, op});
    do apb(0, `REG_STATUS, 0); while (r[`ST_BUSY] !== 1'b0);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    apb(0, `REG_STATUS, 0);
    chk(r & m, e);
  endtask
  // Truncating multiply: allow a few units in the last place
  task ang(input logic [2:0] op, input logic [31:0] x, input logic [31:0] e, input logic [31:0] f);
    logic [31:0] d;
    apb(1, `REG_ACC, x);
    run(op, 8'h00);
    apb(0, `REG_ACC, 0);
    d = (r > e) ? r - e : e - r;
    chk(32'(d <= 32'h4), 32'h1);
    st(32'h1b, f);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 0;
    st(32'h13f, 0);
    $display("test reset done");
    params(4, 32'h10);
    apb(0, `REG_STACK1, 0);
    chk(r, 4);
    for (i = 0; i < 4; i++) mem_w(32'h10 + i, (32'h39463041 >> (24 - 8 * i)) & 32'hff);
    run(`OP_ASCII_TO_HEX, 8'h20);
    mem_chk(32'h20, 32'h9f);
    mem_chk(32'h21, 32'h0a);
    st(32'h24, 0);
    for (i = 0; i < 16; i++) mem_w(32'h40 + i, i);
    params(16, 32'h40);
    run(`OP_HEX_TO_ASCII, 8'h50);
    for (i = 0; i < 16; i++) mem_chk(32'h50 + 2 * i, 32'h30);
    for (i = 0; i < 16; i++) mem_chk(32'h51 + 2 * i, i < 10 ? 32'h30 + i : 32'h37 + i);
    params(32, 32'h50);
    run(`OP_ASCII_TO_HEX, 8'h80);
    for (i = 0; i < 16; i++) mem_chk(32'h80 + i, i);
    $display("test tables done");
    mem_w(32'h90, 32'h47);
    mem_w(32'h91, 32'h35);
    params(2, 32'h90);
    run(`OP_ASCII_TO_HEX, 8'h98);
    mem_chk(32'h98, 32'h05);
    st(32'h20, 32'h20);
    params(4, 32'hfe);
    run(`OP_ASCII_TO_HEX, 8'ha0);
    st(32'h4, 32'h4);
    mem_w(32'hb0, 32'h31);
    params(2, 32'h10);
    @(posedge sys_clk);
    rung_enable <= 0;
    run(`OP_ASCII_TO_HEX, 8'hb0);
    mem_chk(32'hb0, 32'h31);
    @(posedge sys_clk);
    rung_enable <= 1;
    $display("test faults done");
    ang(`OP_DEG_TO_RAD, 32'h43340000, 32'h40490fdb, 32'h08);
    ang(`OP_DEG_TO_RAD, 32'hc4340000, 32'hc1490fdb, 32'h0a);
    ang(`OP_RAD_TO_DEG, 32'h40490fdb, 32'h43340000, 32'h08);
    ang(`OP_RAD_TO_DEG, 32'hc1490fdb, 32'hc4340000, 32'h0a);
    ang(`OP_DEG_TO_RAD, 32'h00000000, 32'h00000000, 32'h09);
    ang(`OP_DEG_TO_RAD, 32'h00800000, 32'h00000000, 32'h19);
    $display("test angles done");
    apb(1, `REG_ACC, 32'h6);
    apb(1, `REG_CMD, {16'h1234, 13'h0, `OP_LOAD_ADDRESS});
    apb(0, `REG_ACC, 0);
    chk(r, 32'h29c);
    apb(0, `REG_STACK1, 0);
    chk(r, 32'h6);
    apb(1, `REG_STACK1, 32'h42340000);
    run(`OP_LOAD_REAL, 8'h00);
    apb(0, `REG_ACC, 0);
    chk(r, 32'h42340000);
    st(32'h08, 32'h08);
    apb(1, `REG_STACK1, 32'h7fc00000);
    run(`OP_LOAD_REAL, 8'h00);
    st(32'h08, 32'h00);
    $display("test loads done");
    report_and_stop;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
